// [core/pos_cmd_pkg.sv]
// Constants and types shared by the motor position command decoder.
// Summary of operation
// [R1] Address byte: 11, four address bits, wire bit, rw
// [R2] Report actual and target as signed 16-bit
// [R3] Safe position 11 bits, high byte padded ones
// [R4] Master ignores unresolved low position bits
// [R5] Status reply order: ident, act, tag, safe, filler
// [R6] Stall information offered beside position values
// [R7] Master requests status with address plus 0xFC
// [R8] Master reads stored bytes with address plus 0x82
// [R9] Reply eight stored bytes in ascending order
// [R10] Go-to-safe moves target to safe position
// [R11] Go-to-safe ignored while stopping or shut down
// [R12] Coil fault forces immediate stop and shutdown
// [R13] Stop while moving raises step loss flag
// [R14] After stop, target takes actual position
// [R15] Immediate stop on master command 0x85
// [R16] Zeroing clears actual and target positions
// [R17] Reload restores every working parameter default
// [R18] Reload keeps actual and target positions
// [R19] Master avoids reload while a motion runs
// [R20] Continuous-run command starts endless motion
// [R21] Codes: status 0xFC, safe 0x84, stop 0x85
// [R22] Codes: zero 0x86, reload 0x87, bytes 0x82
// [R23] General call address accepted for commands; status and stored-byte requests sent by it leave the reply kind unchanged
// [R24] Unknown codes and wrong lengths are ignored
`default_nettype none

package pos_cmd_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int POS_W  = 16;  // Position word
  localparam int SAFE_W = 11;  // Safe position field
  localparam int EXT_W  = POS_W - SAFE_W;
  localparam int IDX_W  = 4;   // Byte counter
  localparam int NVB_N  = 8;   // Stored nonvolatile bytes

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam logic [1:0]       ADDR_FIXED   = 2'h3;   // Bits 7:6 of address
  localparam logic [6:0]       GEN_CALL     = 7'h00;  // General call address
  localparam logic [IDX_W-1:0] IDX_CMD      = 4'h1;   // Command byte slot
  localparam logic [IDX_W-1:0] CMD_FRAME_N  = 4'h2;   // Bytes in command frame
  localparam logic [IDX_W-1:0] IDX_MAX      = 4'hF;   // Counter saturation
  localparam logic [IDX_W-1:0] RD_FIRST     = 4'h1;   // First reply slot
  localparam logic [2:0]       ID2_FIXED    = 3'h7;   // Top of ident byte
  localparam logic [4:0]       SAFE_HI_FILL = 5'h1F;  // Pad over safe[10:8]
  localparam logic [7:0]       FILL_BYTE    = 8'hFF;  // Filler byte

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_STATUS = 8'hFC;
  localparam logic [7:0] CMD_NVREAD = 8'h82;
  localparam logic [7:0] CMD_SAFE   = 8'h84;
  localparam logic [7:0] CMD_STOP   = 8'h85;
  localparam logic [7:0] CMD_ZERO   = 8'h86;
  localparam logic [7:0] CMD_RELOAD = 8'h87;
  localparam logic [7:0] CMD_RUN    = 8'h97;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [SAFE_W-1:0] SAFE_DEFAULT = 11'h000;
  localparam logic [POS_W-1:0]  POS_ZERO     = 16'h0000;

  // Which reply a read frame returns
  typedef enum logic {REPLY_STATUS = 1'b0, REPLY_NVB = 1'b1} reply_t;

  // Immediate stop sequence, Gray from IDLE to WAIT to HOLD; HOLD back to IDLE flips both bits
  typedef enum logic [1:0] {
    STOP_IDLE = 2'b00,
    STOP_WAIT = 2'b01,
    STOP_HOLD = 2'b11
  } stop_state_t;
endpackage

`default_nettype wire

// [core/cmd_link_if.sv]
// Frame parser to command core link.
`default_nettype none

interface cmd_link_if;
  logic                               cmd_valid;   // Complete command frame
  logic [7:0]                         cmd;         // Command code
  logic                               cmd_bcast;   // Came by general call
  logic                               addr_match;  // Frame is for this node
  logic [pos_cmd_pkg::IDX_W-1:0]      read_index;  // Next reply slot

  modport parser (output cmd_valid, cmd, cmd_bcast, addr_match, read_index);
  modport core   (input cmd_valid, cmd, cmd_bcast, addr_match, read_index);
endinterface

`default_nettype wire

// [core/frame_parser.sv]
// Byte level frame tracker: address match, command capture, read slots.
`default_nettype none

module frame_parser (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       start_seen,
  input  wire logic       stop_seen,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       tx_req,
  input  wire logic [3:0] programmable_address_bits,
  input  wire logic       hardwired_address_bit,
  cmd_link_if.parser      link
);
  logic [pos_cmd_pkg::IDX_W-1:0] idx_q, idx_d;  // Bytes received
  logic [pos_cmd_pkg::IDX_W-1:0] rd_q, rd_d;    // Next reply slot
  logic                          match_q, match_d;
  logic                          rw_q, rw_d;
  logic                          bc_q, bc_d;
  logic [7:0]                    cmd_q, cmd_d;
  logic                          valid_q, valid_d;
  logic [6:0]                    own_addr;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // [R1] Address layout check
  assign own_addr = {pos_cmd_pkg::ADDR_FIXED, programmable_address_bits,
                     hardwired_address_bit};

  always_comb begin
    idx_d   = idx_q;
    rd_d    = rd_q;
    match_d = match_q;
    rw_d    = rw_q;
    bc_d    = bc_q;
    cmd_d   = cmd_q;
    valid_d = 1'b0;
    if (start_seen) begin
      // New frame clears byte count and match, sets reply slot back to the first
      idx_d   = '0;
      rd_d    = pos_cmd_pkg::RD_FIRST;
      match_d = 1'b0;
    end else if (rx_valid) begin
      if (idx_q == '0) begin
        rw_d = rx_byte[0];
        bc_d = (rx_byte[7:1] == pos_cmd_pkg::GEN_CALL);
        // [R23] General call accepted for writes
        match_d = (rx_byte[7:1] == own_addr) || (bc_d && !rx_byte[0]);
      end else if (idx_q == pos_cmd_pkg::IDX_CMD) begin
        cmd_d = rx_byte;
      end
      if (idx_q != pos_cmd_pkg::IDX_MAX) begin
        idx_d = idx_q + 1'b1;
      end
    end else if (tx_req && match_q && rw_q && rd_q != pos_cmd_pkg::IDX_MAX) begin
      // Reply slots advance per byte read
      rd_d = rd_q + 1'b1;
    end else if (stop_seen) begin
      // [R24] Only exact two-byte write frames count
      valid_d = match_q && !rw_q && (idx_q == pos_cmd_pkg::CMD_FRAME_N);
      match_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      idx_q   <= '0;
      rd_q    <= pos_cmd_pkg::RD_FIRST;
      match_q <= 1'b0;
      rw_q    <= 1'b0;
      bc_q    <= 1'b0;
      cmd_q   <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      idx_q   <= idx_d;
      rd_q    <= rd_d;
      match_q <= match_d;
      rw_q    <= rw_d;
      bc_q    <= bc_d;
      cmd_q   <= cmd_d;
      valid_q <= valid_d;
    end
  end

  assign link.cmd_valid  = valid_q;
  assign link.cmd        = cmd_q;
  assign link.cmd_bcast  = bc_q;
  assign link.addr_match = match_q;
  assign link.read_index = rd_q;
endmodule // frame_parser

`default_nettype wire

// [core/reply_builder.sv]
// Selects the reply byte for a read slot.
`default_nettype none

module reply_builder (
  input  wire logic                                 kind,
  input  wire logic [pos_cmd_pkg::IDX_W-1:0]        slot,
  input  wire logic [pos_cmd_pkg::POS_W-1:0]        actual_position,
  input  wire logic [pos_cmd_pkg::POS_W-1:0]        target_position,
  input  wire logic [pos_cmd_pkg::SAFE_W-1:0]       safe_position,
  input  wire logic [3:0]                           programmable_address_bits,
  input  wire logic                                 hardwired_address_bit,
  input  wire logic [8*pos_cmd_pkg::NVB_N-1:0]      nvb_bytes,
  output logic [7:0]                                reply
);
  logic [7:0] nvb [pos_cmd_pkg::NVB_N];  // Stored bytes by index

  // Split the stored bytes, byte 0 lowest
  for (genvar i = 0; i < pos_cmd_pkg::NVB_N; i++) begin : g_nvb
    assign nvb[i] = nvb_bytes[8*i +: 8];
  end

  always_comb begin
    reply = pos_cmd_pkg::FILL_BYTE;
    if (kind == pos_cmd_pkg::REPLY_NVB) begin
      // [R9] Stored bytes in ascending order
      if (slot >= 4'h1 && slot <= 4'h8) begin
        reply = nvb[3'(slot - 4'h1)];
      end
    end else begin
      // [R5] Status reply order
      unique case (slot)
        4'h1:    reply = {pos_cmd_pkg::ID2_FIXED, programmable_address_bits,
                          hardwired_address_bit};
        4'h2:    reply = actual_position[15:8];
        4'h3:    reply = actual_position[7:0];
        4'h4:    reply = target_position[15:8];
        4'h5:    reply = target_position[7:0];
        4'h6:    reply = safe_position[7:0];
        // [R3] Safe high bits padded with ones
        4'h7:    reply = {pos_cmd_pkg::SAFE_HI_FILL, safe_position[10:8]};
        default: reply = pos_cmd_pkg::FILL_BYTE;
      endcase
    end
  end
endmodule // reply_builder

`default_nettype wire

// [core/motor_position_command_decoder.sv]
// Top of the motor position command decoder: commands, positions, stop.
`default_nettype none

module motor_position_command_decoder (
  input  wire logic                              mclk,
  input  wire logic                              rst,
  // Byte engine of the serial slave
  input  wire logic                              start_seen,
  input  wire logic                              stop_seen,
  input  wire logic                              rx_valid,
  input  wire logic [7:0]                        rx_byte,
  input  wire logic                              tx_req,
  output logic [7:0]                             tx_byte,
  output logic                                   addr_match,
  // Node address and stored bytes
  input  wire logic [3:0]                        programmable_address_bits,
  input  wire logic                              hardwired_address_bit,
  input  wire logic [8*pos_cmd_pkg::NVB_N-1:0]   nvb_bytes,
  // Motion side
  input  wire logic                              step_pulse,
  input  wire logic                              step_up,
  input  wire logic                              motor_moving,
  input  wire logic                              coil_fault,
  input  wire logic                              step_loss_clear,
  output logic [pos_cmd_pkg::POS_W-1:0]          actual_position,
  output logic [pos_cmd_pkg::POS_W-1:0]          target_position,
  output logic [pos_cmd_pkg::SAFE_W-1:0]         safe_position,
  output logic                                   continuous_run,
  output logic                                   stop_active,
  output logic                                   shutdown,
  output logic                                   step_loss_flag,
  output logic                                   defaults_reloaded
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cmd_link_if link ();

  logic [pos_cmd_pkg::POS_W-1:0]  act_q, act_d;      // Actual position
  logic [pos_cmd_pkg::POS_W-1:0]  tag_q, tag_d;      // Target position
  logic [pos_cmd_pkg::SAFE_W-1:0] safe_q, safe_d;    // Safe position
  logic                           run_q, run_d;      // Continuous motion
  logic                           shut_q, shut_d;    // Shutdown mode
  logic                           loss_q, loss_d;    // Step loss flag
  logic                           rel_q, rel_d;      // Reload pulse
  logic                           kind_q, kind_d;    // Reply selection
  logic [7:0]                     tx_q, tx_d;        // Reply byte
  pos_cmd_pkg::stop_state_t       st_q, st_d;        // Stop sequence
  logic                           stop_q, stop_d;    // Stop sequence busy
  logic [7:0]                     reply;             // Byte for this slot
  logic                           cmd_ok;            // Command frame taken
  logic                           do_safe;           // Go-to-safe accepted
  logic                           do_stop;           // Stop requested
  logic                           do_zero;
  logic                           do_reload;
  logic                           do_run;
  logic [pos_cmd_pkg::POS_W-1:0]  safe_ext;          // Safe as position

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  frame_parser u_parser (
    .mclk                      (mclk),
    .rst                       (rst),
    .start_seen                (start_seen),
    .stop_seen                 (stop_seen),
    .rx_valid                  (rx_valid),
    .rx_byte                   (rx_byte),
    .tx_req                    (tx_req),
    .programmable_address_bits (programmable_address_bits),
    .hardwired_address_bit     (hardwired_address_bit),
    .link                      (link.parser)
  );

  // [R2] Positions reported as signed words
  reply_builder u_reply (
    .kind                      (kind_q),
    .slot                      (link.read_index),
    .actual_position           (act_q),
    .target_position           (tag_q),
    .safe_position             (safe_q),
    .programmable_address_bits (programmable_address_bits),
    .hardwired_address_bit     (hardwired_address_bit),
    .nvb_bytes                 (nvb_bytes),
    .reply                     (reply)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign cmd_ok   = link.cmd_valid;
  // Safe field sign extended to a position
  assign safe_ext = {{pos_cmd_pkg::EXT_W{safe_q[pos_cmd_pkg::SAFE_W-1]}}, safe_q};

  // [R21] Stop code or coil fault
  assign do_stop   = (cmd_ok && link.cmd == pos_cmd_pkg::CMD_STOP) || coil_fault;
  // [R11] Safe move ignored while stopping or shut down
  assign do_safe   = cmd_ok && link.cmd == pos_cmd_pkg::CMD_SAFE && !shut_q
                     && st_q == pos_cmd_pkg::STOP_IDLE && !coil_fault;
  // [R22] Remaining action codes
  assign do_zero   = cmd_ok && link.cmd == pos_cmd_pkg::CMD_ZERO;
  assign do_reload = cmd_ok && link.cmd == pos_cmd_pkg::CMD_RELOAD;
  assign do_run    = cmd_ok && link.cmd == pos_cmd_pkg::CMD_RUN && !shut_q
                     && !coil_fault;

  // ----------------------------------------
  // Reply selection and read data
  // ----------------------------------------
  always_comb begin
    kind_d = kind_q;
    tx_d   = tx_q;
    // [R7] Status request picks the status reply
    if (cmd_ok && !link.cmd_bcast && link.cmd == pos_cmd_pkg::CMD_STATUS) begin
      kind_d = pos_cmd_pkg::REPLY_STATUS;
    end
    // [R8] Stored byte request picks that reply
    if (cmd_ok && !link.cmd_bcast && link.cmd == pos_cmd_pkg::CMD_NVREAD) begin
      kind_d = pos_cmd_pkg::REPLY_NVB;
    end
    // [R5] Next reply byte loaded on request
    if (tx_req && link.addr_match) begin
      tx_d = reply;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      kind_q <= pos_cmd_pkg::REPLY_STATUS;
      tx_q   <= pos_cmd_pkg::FILL_BYTE;
    end else begin
      kind_q <= kind_d;
      tx_q   <= tx_d;
    end
  end

  // ----------------------------------------
  // Immediate stop sequence
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      pos_cmd_pkg::STOP_IDLE: if (do_stop) st_d = pos_cmd_pkg::STOP_WAIT;
      // Wait for the motor to come to rest
      pos_cmd_pkg::STOP_WAIT: if (!motor_moving) st_d = pos_cmd_pkg::STOP_HOLD;
      // One cycle to copy actual into target
      pos_cmd_pkg::STOP_HOLD: st_d = do_stop ? pos_cmd_pkg::STOP_WAIT
                                              : pos_cmd_pkg::STOP_IDLE;
      default:                st_d = pos_cmd_pkg::STOP_IDLE;
    endcase
    // Busy flag registered so the output leaves a flip-flop
    stop_d = (st_d != pos_cmd_pkg::STOP_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q   <= pos_cmd_pkg::STOP_IDLE;
      stop_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      stop_q <= stop_d;
    end
  end

  // ----------------------------------------
  // Positions, parameters and flags
  // ----------------------------------------
  always_comb begin
    act_d  = act_q;
    tag_d  = tag_q;
    safe_d = safe_q;
    run_d  = run_q;
    shut_d = shut_q;
    loss_d = loss_q;
    rel_d  = 1'b0;
    // Actual position follows the step engine
    if (step_pulse) begin
      act_d = step_up ? act_q + 1'b1 : act_q - 1'b1;
    end
    // [R14] Hold the stop position
    if (st_q == pos_cmd_pkg::STOP_HOLD) begin
      tag_d = act_q;
    end
    // [R10] Target becomes the safe position
    if (do_safe) begin
      tag_d = safe_ext;
      run_d = 1'b0;
    end
    // [R20] Enter continuous motion
    if (do_run) begin
      run_d = 1'b1;
    end
    // [R17] Working parameters back to defaults
    if (do_reload) begin
      safe_d = pos_cmd_pkg::SAFE_DEFAULT;
      run_d  = 1'b0;
      shut_d = 1'b0;
      rel_d  = 1'b1;
    end
    // [R15] Stop cancels continuous motion
    if (do_stop) begin
      run_d = 1'b0;
    end
    // [R12] Coil fault leads to shutdown
    if (coil_fault) begin
      shut_d = 1'b1;
    end
    // [R16] Zeroing wins over stepping and copying
    if (do_zero) begin
      act_d = pos_cmd_pkg::POS_ZERO;
      tag_d = pos_cmd_pkg::POS_ZERO;
    end
    // [R13] Stop while moving, set wins over clear
    if (step_loss_clear) begin
      loss_d = 1'b0;
    end
    if (do_stop && motor_moving) begin
      loss_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      act_q  <= pos_cmd_pkg::POS_ZERO;
      tag_q  <= pos_cmd_pkg::POS_ZERO;
      safe_q <= pos_cmd_pkg::SAFE_DEFAULT;
      run_q  <= 1'b0;
      shut_q <= 1'b0;
      loss_q <= 1'b0;
      rel_q  <= 1'b0;
    end else begin
      act_q  <= act_d;
      tag_q  <= tag_d;
      safe_q <= safe_d;
      run_q  <= run_d;
      shut_q <= shut_d;
      loss_q <= loss_d;
      rel_q  <= rel_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tx_byte           = tx_q;
  assign addr_match        = link.addr_match;
  assign actual_position   = act_q;
  assign target_position   = tag_q;
  assign safe_position     = safe_q;
  assign continuous_run    = run_q;
  assign stop_active       = stop_q;
  assign shutdown          = shut_q;
  // [R6] Stall information beside positions
  assign step_loss_flag    = loss_q;
  assign defaults_reloaded = rel_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_settled;
    st_q == pos_cmd_pkg::STOP_HOLD && !do_zero;
  endsequence

  sequence s_stop_moving;
    do_stop && motor_moving;
  endsequence

  a_zero_clears_pos: assert property (do_zero |=> act_q == '0 && tag_q == '0) // [R16]
    else $error("zero command did not clear positions");
  a_reload_keeps_tag: assert property ( // [R18]
    do_reload && st_q != pos_cmd_pkg::STOP_HOLD |=> $stable(tag_q))
    else $error("reload changed target position");
  a_reload_defaults: assert property ( // [R17]
    do_reload |=> safe_q == pos_cmd_pkg::SAFE_DEFAULT && !run_q && rel_q ##1 !rel_q)
    else $error("reload did not restore defaults");
  a_fault_shutdown: assert property ( // [R12]
    coil_fault |=> shut_q && st_q != pos_cmd_pkg::STOP_IDLE)
    else $error("coil fault did not stop and shut down");
  a_step_loss_set: assert property (s_stop_moving |=> loss_q) // [R13]
    else $error("step loss not raised");
  a_stop_holds_pos: assert property (s_settled |=> tag_q == $past(act_q)) // [R14]
    else $error("target not copied from actual after stop");
  a_stop_reaches_hold: assert property ( // [R15]
    st_q == pos_cmd_pkg::STOP_WAIT && !motor_moving |=> st_q == pos_cmd_pkg::STOP_HOLD)
    else $error("stop did not settle");
  a_safe_target: assert property (do_safe && !do_zero |=> tag_q == $past(safe_ext)) // [R10]
    else $error("safe position not applied");
  a_safe_ignored: assert property ( // [R11]
    cmd_ok && link.cmd == pos_cmd_pkg::CMD_SAFE && shut_q
    && st_q == pos_cmd_pkg::STOP_IDLE |=> $stable(tag_q) || $past(do_zero))
    else $error("go-to-safe acted in shutdown");
  a_run_starts: assert property (do_run |=> run_q) // [R20]
    else $error("continuous run not entered");
  a_status_ident: assert property ( // [R5]
    tx_req && link.addr_match && kind_q == pos_cmd_pkg::REPLY_STATUS
    && link.read_index == pos_cmd_pkg::RD_FIRST
    |=> tx_byte == {pos_cmd_pkg::ID2_FIXED, $past(programmable_address_bits),
                    $past(hardwired_address_bit)})
    else $error("status ident byte wrong");
endmodule // motor_position_command_decoder

`default_nettype wire

// [test/bus_master_model.sv]
// Bus master model driving the byte engine strobes of the decoder.
`default_nettype none

module bus_master_model (
  input  wire logic       mclk,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus; the data byte shows junk until one is written
  initial begin
    {start_seen, stop_seen, rx_valid, tx_req} = 4'h0;
    rx_byte = 8'h5A;
  end

  // One strobe per call: 0 start, 1 byte, 2 read request, 3 stop
  task automatic ev(input int k, input logic [7:0] b);
    @(posedge mclk);
    start_seen <= (k == 0);
    rx_valid   <= (k == 1);
    tx_req     <= (k == 2);
    stop_seen  <= (k == 3);
    if (k == 1) rx_byte <= b;
    @(posedge mclk);
    {start_seen, rx_valid, tx_req, stop_seen} <= 4'h0;
    // Released byte flips so a stale value never looks valid
    rx_byte <= ~rx_byte;
  endtask

  task automatic send(input logic [7:0] a, input logic [7:0] c);
    ev(0, 8'h00);
    ev(1, a);
    ev(1, c);
    ev(3, 8'h00);
    repeat (3) @(posedge mclk);
  endtask
endmodule // bus_master_model

`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the motor position command decoder.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  ADR = 8'hEA;  // Write address: pa A, wire bit 1
  localparam logic [63:0] NVB = 64'h0123_4567_89AB_CDEF;
  logic        mclk, rst, start_seen, stop_seen, rx_valid, tx_req, addr_match;
  logic [7:0]  rx_byte, tx_byte;
  logic        step_pulse, step_up, motor_moving, coil_fault, step_loss_clear;
  logic [15:0] actual_position, target_position;
  logic [10:0] safe_position;
  logic        continuous_run, stop_active, shutdown, step_loss_flag, defaults_reloaded;
  int          errors, checked;
  logic [15:0] act_e;      // Expected actual position
  logic [7:0]  exp_q[$];   // Expected reply bytes

  bus_master_model i_master (.mclk(mclk), .start_seen(start_seen), .stop_seen(stop_seen),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req));
  motor_position_command_decoder i_dut (.mclk(mclk), .rst(rst), .start_seen(start_seen),
    .stop_seen(stop_seen), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req),
    .tx_byte(tx_byte), .addr_match(addr_match), .programmable_address_bits(4'hA),
    .hardwired_address_bit(1'b1), .nvb_bytes(NVB), .step_pulse(step_pulse),
    .step_up(step_up), .motor_moving(motor_moving), .coil_fault(coil_fault),
    .step_loss_clear(step_loss_clear), .actual_position(actual_position),
    .target_position(target_position), .safe_position(safe_position),
    .continuous_run(continuous_run), .stop_active(stop_active), .shutdown(shutdown),
    .step_loss_flag(step_loss_flag), .defaults_reloaded(defaults_reloaded));

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Steps from the motion engine, tracked in the model
  task automatic step(input logic up, input int n);
    repeat (n) begin
      @(posedge mclk);
      step_pulse <= 1'b1;
      step_up    <= up;
      @(posedge mclk);
      step_pulse <= 1'b0;
      act_e = up ? act_e + 16'h0001 : act_e - 16'h0001;
    end
  endtask

  // Request a reply kind, then read and compare every queued byte
  task automatic rd(input logic [7:0] c);
    i_master.send(ADR, c);
    i_master.ev(0, 8'h00);
    i_master.ev(1, ADR | 8'h01);
    foreach (exp_q[i]) begin
      i_master.ev(2, 8'h00);
      #1 chk("tx_byte", 16'(exp_q[i]), 16'(tx_byte));
    end
    i_master.ev(3, 8'h00);
    exp_q.delete();
  endtask

  task automatic t_nvb();
    for (int i = 0; i < 8; i++) exp_q.push_back(NVB[8*i+:8]);
    exp_q.push_back(8'hFF);
    rd(8'h82);
  endtask

  // Full resolution assumed, so every position bit is compared
  task automatic t_status();
    step(1'b0, 5);
    exp_q = '{8'hF5, act_e[15:8], act_e[7:0], 8'h00, 8'h00, 8'h00, 8'hF8, 8'hFF, 8'hFF};
    rd(8'hFC);
  endtask

  task automatic t_refuse();
    i_master.ev(0, 8'h00);
    i_master.ev(1, 8'hEC);
    #1 chk("addr_match", 16'h0000, 16'(addr_match));
    i_master.ev(3, 8'h00);
    i_master.ev(0, 8'h00);
    i_master.ev(1, ADR);
    i_master.ev(1, 8'h86);
    i_master.ev(1, 8'h86);
    i_master.ev(3, 8'h00);
    repeat (3) @(posedge mclk);
    chk("actual", act_e, actual_position);
  endtask

  task automatic t_stop();
    i_master.send(8'h00, 8'h86);
    act_e = 16'h0000;
    chk("zero", 16'h0000, actual_position | target_position);
    i_master.send(ADR, 8'h97);
    chk("run", 16'h0001, 16'(continuous_run));
    motor_moving <= 1'b1;
    i_master.send(ADR, 8'h85);
    chk("stop", 16'h0003, 16'({continuous_run, stop_active, step_loss_flag}));
    step(1'b0, 2);
    motor_moving <= 1'b0;
    for (int i = 0; i < 10 && stop_active !== 1'b0; i++) @(posedge mclk);
    chk("stop_idle", 16'h0000, 16'(stop_active));
    chk("hold", act_e, target_position);
  endtask

  task automatic t_fault();
    coil_fault <= 1'b1;
    @(posedge mclk);
    coil_fault <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("shutdown", 16'h0001, 16'(shutdown));
    i_master.send(ADR, 8'h84);
    chk("ignored", act_e, target_position);
    // Motor at rest before the reload frame
    i_master.ev(0, 8'h00);
    i_master.ev(1, ADR);
    i_master.ev(1, 8'h87);
    i_master.ev(3, 8'h00);
    @(posedge mclk);
    #1 chk("reload_pulse", 16'h0001, 16'(defaults_reloaded));
    @(posedge mclk);
    #1 chk("pulse_end", 16'h0000, 16'(defaults_reloaded));
    chk("reload", 16'h0000, 16'(shutdown));
    chk("kept", act_e, actual_position);
    i_master.send(ADR, 8'h84);
    chk("safe", 16'h0000, target_position);
    i_master.send(ADR, 8'h81);
    chk("unknown", act_e, actual_position);
    step_loss_clear <= 1'b1;
    @(posedge mclk);
    step_loss_clear <= 1'b0;
    @(posedge mclk);
    chk("clear", 16'h0000, 16'(step_loss_flag));
  endtask

  initial begin
    {rst, step_pulse, step_up, motor_moving, coil_fault, step_loss_clear} = 6'h20;
    act_e = 16'h0000;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("tx_byte", 16'h00FF, 16'(tx_byte));
    t_nvb();
    t_status();
    t_refuse();
    t_stop();
    t_fault();
    end_sim();
  end

  // Hang guard
  initial begin
    #2000000;
    errors++;
    end_sim();
  end
endmodule // tb

`default_nettype wire
